// ### core/rtcas_pkg.sv
// constants shared by the timekeeping and supervisor core
package rtcas_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;
  localparam logic [6:0] ADDR_SEC = 7'h00;
  localparam logic [6:0] ADDR_YEAR = 7'h06;
  localparam logic [6:0] ADDR_ALM_SEC = 7'h07;
  localparam logic [6:0] ADDR_ALM_DAY = 7'h0a;
  localparam logic [6:0] ADDR_CTRL = 7'h0b;
  localparam logic [6:0] ADDR_STAT = 7'h0c;
  localparam logic [6:0] ADDR_WDOG = 7'h0d;
  localparam logic [6:0] ADDR_ADC = 7'h0e;
  // writable bits of registers 00h-0Ah, 0Bh, 0Dh
  localparam logic [7:0] TK_MASK [0:6] = '{8'h7f, 8'h7f, 8'h7f, 8'h07, 8'h3f, 8'h1f, 8'hff};
  localparam logic [7:0] ALM_MASK [0:3] = '{8'hff, 8'hff, 8'hff, 8'h87};
  localparam logic [7:0] CTRL_MASK = 8'hf1;
  localparam logic [7:0] WDOG_MASK = 8'h03;
  localparam logic [7:0] TK_RESET [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] ALM_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] WDOG_RESET = 2'h3;
  localparam int CTRL_OSC_STOP = 7;
  localparam int CTRL_WP = 6;
  localparam int CTRL_AIS_HI = 5;
  localparam int CTRL_AIS_LO = 4;
  localparam int CTRL_AIE = 0;
  localparam int HR_MODE12 = 6;
  localparam int HR_PM = 5;
  localparam int ALM_MASK_BIT = 7;
  localparam int RESET_HOLD_MS = 250;
  localparam int WDOG_MS_1 = 250;
  localparam int WDOG_MS_2 = 500;
  localparam int WDOG_MS_3 = 1000;
  localparam int CU_WINDOW_US = 488;
  localparam int CU_QUIET_US = 244;
  // synchroniser slots and their reset levels
  localparam int SY_OSC = 0;
  localparam int SY_VCC_OK = 1;
  localparam int SY_BATT = 2;
  localparam int SY_PF_LOW = 3;
  localparam int SY_BAT_LOW = 4;
  localparam int SY_STROBE_N = 5;
  localparam int SY_RST_PIN = 6;
  localparam int SY_SRAM_N = 7;
  localparam logic [7:0] SYNC_RESET = 8'he0;
  typedef enum logic [2:0] {SV_POWERUP, SV_RUN, SV_DEBOUNCE, SV_WAIT_RELEASE, SV_HOLD} rtcas_sv_t;
endpackage

// ### core/rtcas_top.sv
// clock, calendar, alarm, control registers and processor supervisor
`timescale 1ns/100ps
`default_nettype none
module rtcas_top #(
  parameter int OSC_PER_SEC = 32768,
  parameter int US_PER_MS = 1000,
  parameter int CONV_PERIOD_US = 10000,
  parameter int OSC_STARTUP_MS = 1000
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic osc_32k_i,
  input wire logic vcc_ok_i,
  input wire logic battery_mode_i,
  input wire logic powerfail_sense_low_i,
  input wire logic battery_low_i,
  input wire logic watchdog_strobe_n_i,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  input wire logic sram_enable_in_n_i,
  output logic sram_enable_out_n_o,
  output logic powerfail_warn_out_n_o,
  output logic irq_o,
  output logic analog_select_hi_o,
  output logic analog_select_lo_o,
  input wire logic [7:0] adc_result_i,
  output logic adc_update_o
);
  logic [7:0] meta;
  logic [7:0] syn;
  logic [7:0] syn_d;
  wire [7:0] pin_raw = {sram_enable_in_n_i, rst_pin_i, watchdog_strobe_n_i, battery_low_i,
                        powerfail_sense_low_i, battery_mode_i, vcc_ok_i, osc_32k_i};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta[gi] <= rtcas_pkg::SYNC_RESET[gi];
          syn[gi] <= rtcas_pkg::SYNC_RESET[gi];
          syn_d[gi] <= rtcas_pkg::SYNC_RESET[gi];
        end else begin
          meta[gi] <= pin_raw[gi];
          syn[gi] <= meta[gi];
          syn_d[gi] <= syn[gi];
        end
      end
    end
  endgenerate
  wire vcc_ok = syn[rtcas_pkg::SY_VCC_OK];
  wire on_battery = syn[rtcas_pkg::SY_BATT];
  wire osc_rise = syn[rtcas_pkg::SY_OSC] & ~syn_d[rtcas_pkg::SY_OSC];
  wire strobe_fall = ~syn[rtcas_pkg::SY_STROBE_N] & syn_d[rtcas_pkg::SY_STROBE_N];
  wire pin_fall = ~syn[rtcas_pkg::SY_RST_PIN] & syn_d[rtcas_pkg::SY_RST_PIN];
  wire pin_rise = syn[rtcas_pkg::SY_RST_PIN] & ~syn_d[rtcas_pkg::SY_RST_PIN];

  // registers
  logic [7:0] tk [0:6];
  logic [7:0] alm [0:3];
  logic [7:0] ctrl;
  logic [1:0] wdog_td;
  logic [7:0] adc_reg;
  logic alarm_flag;
  wire osc_stop_bit = ctrl[rtcas_pkg::CTRL_OSC_STOP];
  wire wp = ctrl[rtcas_pkg::CTRL_WP];
  wire [1:0] ais = {ctrl[rtcas_pkg::CTRL_AIS_HI], ctrl[rtcas_pkg::CTRL_AIS_LO]};
  wire alarm_irq_enable = ctrl[rtcas_pkg::CTRL_AIE];

  // only control stays writable under protection, else the lock could never be lifted
  wire wr_ok = reg_wr_i & (~wp | (reg_addr_i == rtcas_pkg::ADDR_CTRL));
  wire alm_access = (reg_wr_i | reg_rd_i) & (reg_addr_i >= rtcas_pkg::ADDR_ALM_SEC)
                    & (reg_addr_i <= rtcas_pkg::ADDR_ALM_DAY);

  // time bases
  logic [15:0] osc_div;
  logic [3:0] us_div;
  logic [9:0] ms_div;
  wire us_tick = (us_div == 4'(rtcas_pkg::CYCLES_PER_US - 1));
  wire ms_tick = us_tick & (ms_div == 10'(US_PER_MS - 1));
  wire osc_wrap = osc_rise & (osc_div == 16'(OSC_PER_SEC - 1));
  wire sec_tick = osc_wrap & ~osc_stop_bit;
  logic sec_tick_d;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_div <= '0;
      us_div <= '0;
      ms_div <= '0;
      sec_tick_d <= 1'b0;
    end else begin
      osc_div <= osc_wrap ? '0 : (osc_rise ? osc_div + 16'd1 : osc_div);
      us_div <= us_tick ? '0 : us_div + 4'd1;
      ms_div <= ms_tick ? '0 : (us_tick ? ms_div + 10'd1 : ms_div);
      sec_tick_d <= sec_tick;
    end
  end

  // BCD increment and month-length helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction
  function automatic logic [7:0] month_last(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mo)
      8'h02: month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction

  logic [7:0] next_tk [0:6];
  wire [7:0] hr = tk[2];
  wire mode12 = hr[rtcas_pkg::HR_MODE12];
  wire sec_wrap = (tk[0] == 8'h59);
  wire min_wrap = sec_wrap & (tk[1] == 8'h59);
  wire day_wrap = min_wrap & (mode12 ? (hr[5] & hr[4:0] == 5'h11) : (hr[5:0] == 6'h23));
  wire date_wrap = day_wrap & (tk[4] == month_last(tk[5], tk[6]));
  wire month_wrap = date_wrap & (tk[5] == 8'h12);
  always_comb begin
    next_tk[0] = sec_wrap ? 8'h00 : bcd_inc(tk[0]);
    next_tk[1] = !sec_wrap ? tk[1] : (min_wrap ? 8'h00 : bcd_inc(tk[1]));
    next_tk[2] = hr;
    if (min_wrap) begin
      if (mode12) begin
        // bit 5 flips going 11 -> 12
        if (hr[4:0] == 5'h12) begin
          next_tk[2] = {hr[7:5], 5'h01};
        end else if (hr[4:0] == 5'h11) begin
          next_tk[2] = {hr[7:6], ~hr[5], 5'h12};
        end else begin
          next_tk[2] = {hr[7:5], 5'(bcd_inc({3'b000, hr[4:0]}))};
        end
      end else begin
        next_tk[2] = (hr[5:0] == 6'h23) ? {hr[7:6], 6'h00}
                     : {hr[7:6], 6'(bcd_inc({2'b00, hr[5:0]}))};
      end
    end
    next_tk[3] = !day_wrap ? tk[3] : ((tk[3] == 8'h07) ? 8'h01 : bcd_inc(tk[3]));
    next_tk[4] = !day_wrap ? tk[4] : (date_wrap ? 8'h01 : bcd_inc(tk[4]));
    next_tk[5] = !date_wrap ? tk[5] : (month_wrap ? 8'h01 : bcd_inc(tk[5]));
    next_tk[6] = !month_wrap ? tk[6] : ((tk[6] == 8'h99) ? 8'h00 : bcd_inc(tk[6]));
  end

  generate
    for (gi = 0; gi < 7; gi++) begin : g_tk
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          tk[gi] <= rtcas_pkg::TK_RESET[gi];
        end else if (wr_ok && reg_addr_i == 7'(gi)) begin
          tk[gi] <= reg_wdata_i & rtcas_pkg::TK_MASK[gi];
        end else if (sec_tick) begin
          tk[gi] <= next_tk[gi];
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_alm
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          alm[gi] <= rtcas_pkg::ALM_RESET;
        end else if (wr_ok && reg_addr_i == 7'(gi + 7)) begin
          alm[gi] <= reg_wdata_i & rtcas_pkg::ALM_MASK[gi];
        end
      end
    end
  endgenerate

  // each field matches when masked or equal to its time register
  logic [3:0] fld_hit;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_hit
      assign fld_hit[gi] = alm[gi][rtcas_pkg::ALM_MASK_BIT]
                           | (alm[gi][6:0] == tk[gi][6:0]);
    end
  endgenerate
  // compared the cycle after the counters advance
  wire alarm_set = sec_tick_d & (&fld_hit);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= rtcas_pkg::CTRL_RESET;
      wdog_td <= rtcas_pkg::WDOG_RESET;
      alarm_flag <= 1'b0;
    end else begin
      if (wr_ok && reg_addr_i == rtcas_pkg::ADDR_CTRL) begin
        ctrl <= reg_wdata_i & rtcas_pkg::CTRL_MASK;
      end
      if (wr_ok && reg_addr_i == rtcas_pkg::ADDR_WDOG) begin
        wdog_td <= reg_wdata_i[1:0];
      end
      // a match in the clearing cycle still sets the flag
      alarm_flag <= alarm_set | (alarm_flag & ~alm_access);
    end
  end

  // conversion schedule: update each period, first one within the window
  logic [15:0] conv_us;
  logic [1:0] ais_d;
  wire conv_on = (ais != 2'b00);
  wire conv_due = us_tick & conv_on & (conv_us == 16'(CONV_PERIOD_US - 1));
  wire conversion_pending = conv_on
                            & (conv_us >= 16'(CONV_PERIOD_US - rtcas_pkg::CU_WINDOW_US));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_us <= '0;
      ais_d <= 2'b00;
      adc_reg <= 8'h00;
      adc_update_o <= 1'b0;
    end else begin
      ais_d <= ais;
      adc_update_o <= conv_due;
      if (!conv_on) begin
        conv_us <= '0;
      end else if (ais_d == 2'b00) begin
        conv_us <= 16'(CONV_PERIOD_US - rtcas_pkg::CU_WINDOW_US);
      end else if (us_tick) begin
        conv_us <= conv_due ? '0 : conv_us + 16'd1;
      end
      if (conv_due) begin
        adc_reg <= adc_result_i;
      end
    end
  end

  // supervisor
  rtcas_pkg::rtcas_sv_t sv_state, next_sv_state;
  logic [11:0] hold_ms;
  logic [9:0] wdog_ms;
  logic osc_stopped_backup;
  logic drive_rst;
  wire [11:0] pu_target = 12'(rtcas_pkg::RESET_HOLD_MS)
                          + (osc_stopped_backup ? 12'(OSC_STARTUP_MS) : 12'd0);
  wire hold_done = ms_tick & (hold_ms >= 12'(rtcas_pkg::RESET_HOLD_MS - 1));
  wire pu_done = ms_tick & (hold_ms >= pu_target - 12'd1);
  logic [9:0] wdog_limit;
  always_comb begin
    case (wdog_td)
      2'b01: wdog_limit = 10'(rtcas_pkg::WDOG_MS_1);
      2'b10: wdog_limit = 10'(rtcas_pkg::WDOG_MS_2);
      2'b11: wdog_limit = 10'(rtcas_pkg::WDOG_MS_3);
      default: wdog_limit = 10'd0;
    endcase
  end
  wire wdog_timeout = (wdog_td != 2'b00) & ms_tick & (wdog_ms >= wdog_limit - 10'd1);

  always_comb begin
    next_sv_state = sv_state;
    case (sv_state)
      rtcas_pkg::SV_POWERUP: if (pu_done) next_sv_state = rtcas_pkg::SV_RUN;
      rtcas_pkg::SV_RUN: begin
        if (pin_fall) begin
          next_sv_state = rtcas_pkg::SV_DEBOUNCE;
        end else if (wdog_timeout) begin
          next_sv_state = rtcas_pkg::SV_HOLD;
        end
      end
      rtcas_pkg::SV_DEBOUNCE: if (hold_done) next_sv_state = rtcas_pkg::SV_WAIT_RELEASE;
      rtcas_pkg::SV_WAIT_RELEASE: if (pin_rise) next_sv_state = rtcas_pkg::SV_HOLD;
      rtcas_pkg::SV_HOLD: if (hold_done) next_sv_state = rtcas_pkg::SV_RUN;
      default: next_sv_state = rtcas_pkg::SV_POWERUP;
    endcase
    if (!vcc_ok) begin
      next_sv_state = rtcas_pkg::SV_POWERUP;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sv_state <= rtcas_pkg::SV_POWERUP;
      hold_ms <= '0;
      wdog_ms <= '0;
      osc_stopped_backup <= 1'b0;
      drive_rst <= 1'b1;
    end else begin
      sv_state <= next_sv_state;
      hold_ms <= (next_sv_state != sv_state || !vcc_ok) ? '0
                 : (ms_tick ? hold_ms + 12'd1 : hold_ms);
      // restarts whenever reset is active or the strobe falls
      wdog_ms <= (sv_state != rtcas_pkg::SV_RUN || strobe_fall || wdog_timeout) ? '0
                 : (ms_tick ? wdog_ms + 10'd1 : wdog_ms);
      if (on_battery && osc_stop_bit) begin
        osc_stopped_backup <= 1'b1;
      end else if (sv_state == rtcas_pkg::SV_POWERUP && pu_done) begin
        osc_stopped_backup <= 1'b0;
      end
      drive_rst <= !vcc_ok || next_sv_state == rtcas_pkg::SV_POWERUP
                   || next_sv_state == rtcas_pkg::SV_DEBOUNCE
                   || next_sv_state == rtcas_pkg::SV_HOLD;
    end
  end

  // pins and read port
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr_i <= rtcas_pkg::ADDR_YEAR) begin
      next_rdata = tk[reg_addr_i[2:0]];
    end else if (reg_addr_i <= rtcas_pkg::ADDR_ALM_DAY) begin
      next_rdata = alm[2'(reg_addr_i - rtcas_pkg::ADDR_ALM_SEC)];
    end else if (reg_addr_i == rtcas_pkg::ADDR_CTRL) begin
      next_rdata = ctrl;
    end else if (reg_addr_i == rtcas_pkg::ADDR_STAT) begin
      next_rdata = {conversion_pending, syn[rtcas_pkg::SY_BAT_LOW], 5'b00000, alarm_flag};
    end else if (reg_addr_i == rtcas_pkg::ADDR_WDOG) begin
      next_rdata = {6'b000000, wdog_td};
    end else if (reg_addr_i == rtcas_pkg::ADDR_ADC) begin
      next_rdata = adc_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
      sram_enable_out_n_o <= 1'b1;
      powerfail_warn_out_n_o <= 1'b0;
      irq_o <= 1'b0;
      analog_select_hi_o <= 1'b0;
      analog_select_lo_o <= 1'b0;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
      sram_enable_out_n_o <= (!vcc_ok || sv_state == rtcas_pkg::SV_POWERUP)
                             | syn[rtcas_pkg::SY_SRAM_N];
      powerfail_warn_out_n_o <= ~on_battery & ~syn[rtcas_pkg::SY_PF_LOW];
      irq_o <= alarm_flag & alarm_irq_enable;
      analog_select_hi_o <= ais[1];
      analog_select_lo_o <= ais[0];
    end
  end
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_n_o = ~drive_rst;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_rsvd_zero: assert property (reg_rd_i && reg_addr_i > rtcas_pkg::ADDR_ADC |=> reg_rdata_o == 8'h00) else $error("reserved read not zero");
  chk_sec_bcd: assert property (tk[0][3:0] <= 4'h9 |=> tk[0][3:0] <= 4'h9) else $error("seconds not bcd");
  chk_wp_block: assert property (reg_wr_i && wp && reg_addr_i == rtcas_pkg::ADDR_SEC && !sec_tick |=> tk[0] == $past(tk[0])) else $error("write passed protection");
  chk_osc_stop: assert property (osc_stop_bit && !reg_wr_i |=> tk[0] == $past(tk[0])) else $error("clock ran while stopped");
  chk_irq_gate: assert property (!alarm_irq_enable |=> !irq_o) else $error("irq without enable");
  chk_flag_clear: assert property (alm_access && !alarm_set |=> !alarm_flag) else $error("alarm flag not cleared");
  chk_flag_set: assert property (alarm_set |=> alarm_flag) else $error("alarm flag lost");
  chk_ce_block: assert property (!vcc_ok |=> sram_enable_out_n_o) else $error("sram enabled on power fail");
  chk_pf_batt: assert property (on_battery |=> !powerfail_warn_out_n_o) else $error("warn high on battery");
  chk_rst_vcc: assert property (!vcc_ok |=> !rst_pin_oe_n_o) else $error("reset released with bad supply");
  chk_wdog_fire: assert property (sv_state == rtcas_pkg::SV_RUN && wdog_timeout && !pin_fall && vcc_ok |=> sv_state == rtcas_pkg::SV_HOLD ##1 !rst_pin_oe_n_o) else $error("watchdog did not reset");
  chk_cu_quiet: assert property (conv_on && !conversion_pending |-> 16'(CONV_PERIOD_US) - conv_us > 16'(rtcas_pkg::CU_QUIET_US)) else $error("update too close");
  cov_alarm: cover property (alarm_set ##1 irq_o);
  cov_button: cover property (sv_state == rtcas_pkg::SV_WAIT_RELEASE ##[1:1000] sv_state == rtcas_pkg::SV_HOLD);
  cov_wdog: cover property (wdog_timeout && sv_state == rtcas_pkg::SV_RUN);
endmodule
`default_nettype wire

// ### tb/rtcas_host_model.sv
// host model: pulled-up reset line, push-button and watchdog strobe
`timescale 1ns/100ps
`default_nettype none
module rtcas_host_model (
  input wire logic sys_clk_i,
  input wire logic dev_level_i,
  input wire logic dev_oe_n_i,
  input wire logic button_i,
  input wire logic strobe_en_i,
  output logic rst_line_o,
  output logic strobe_n_o
);
  logic [9:0] cnt = 10'h000;
  // pull-up: line high unless device or button pulls it down
  assign rst_line_o = ~button_i & (dev_oe_n_i | dev_level_i);
  // strobe every 500 cycles, far inside the shortest period
  always_ff @(posedge sys_clk_i) begin
    cnt <= (cnt == 10'h1f3) ? 10'h000 : cnt + 10'h001;
  end
  assign strobe_n_o = ~(strobe_en_i & (cnt < 10'h002));
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the clock, alarm and supervisor core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] addr = 7'h00;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic osc = 1'b0;
  logic vcc_ok = 1'b1;
  logic pf_low = 1'b0;
  logic bat_low = 1'b0;
  logic button = 1'b0;
  logic strobe_en = 1'b1;
  logic batt = 1'b0;
  logic sram_in_n = 1'b0;
  logic [7:0] rdata;
  logic strobe_n, rst_line, rst_drv, oe_n, sram_out_n, pfo_n, irq, ais_hi, ais_lo, adc_upd;
  logic [7:0] v;
  logic [7:0] s0;
  int failures = 0;
  int checks_done = 0;
  int n;
  always #50 sys_clk_i = ~sys_clk_i;
  // eight clocks per oscillator period, so a second is 64 clocks
  always begin
    repeat (4) @(posedge sys_clk_i);
    osc <= ~osc;
  end
  rtcas_top #(.OSC_PER_SEC(8), .US_PER_MS(4), .CONV_PERIOD_US(600), .OSC_STARTUP_MS(4))
  rtcas_top_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .osc_32k_i(osc), .vcc_ok_i(vcc_ok), .battery_mode_i(batt),
    .powerfail_sense_low_i(pf_low), .battery_low_i(bat_low),
    .watchdog_strobe_n_i(strobe_n), .rst_pin_i(rst_line), .rst_pin_o(rst_drv),
    .rst_pin_oe_n_o(oe_n), .sram_enable_in_n_i(sram_in_n), .sram_enable_out_n_o(sram_out_n),
    .powerfail_warn_out_n_o(pfo_n), .irq_o(irq), .analog_select_hi_o(ais_hi),
    .analog_select_lo_o(ais_lo), .adc_result_i(8'h5a), .adc_update_o(adc_upd));
  rtcas_host_model rtcas_host_model_inst (.sys_clk_i(sys_clk_i), .dev_level_i(rst_drv),
    .dev_oe_n_i(oe_n), .button_i(button), .strobe_en_i(strobe_en),
    .rst_line_o(rst_line), .strobe_n_o(strobe_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [6:0] a);
    @(posedge sys_clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk_i);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_oe(input logic lvl, input int lim);
    n = 0;
    while (oe_n !== lvl && n < lim) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
  endtask
  task automatic t_powerup;
    wait_oe(1'b1, 12000);
    chk({7'h00, n >= 9900}, 8'h01);
    chk({7'h00, oe_n}, 8'h01);
    repeat (5) @(posedge sys_clk_i);
    chk({7'h00, sram_out_n}, 8'h00);
    sram_in_n <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    chk({7'h00, sram_out_n}, 8'h01);
    sram_in_n <= 1'b0;
    $display("done: powerup");
  endtask
  task automatic t_regs;
    rdr(rtcas_pkg::ADDR_CTRL);
    chk(v, 8'h00);
    rdr(rtcas_pkg::ADDR_WDOG);
    chk(v, 8'h03);
    wrr(7'h20, 8'hff);
    rdr(7'h20);
    chk(v, 8'h00);
    wrr(rtcas_pkg::ADDR_CTRL, 8'h8e);
    rdr(rtcas_pkg::ADDR_CTRL);
    chk(v, 8'h80);
    rdr(7'h00);
    s0 = v;
    repeat (200) @(posedge sys_clk_i);
    rdr(7'h00);
    chk(v, s0);
    wrr(7'h02, 8'hf2);
    rdr(7'h02);
    chk(v, 8'h72);
    // minutes moved on during power-up, so pin them before locking
    wrr(7'h01, 8'h15);
    wrr(rtcas_pkg::ADDR_CTRL, 8'hc0);
    wrr(7'h01, 8'h37);
    rdr(7'h01);
    chk(v, 8'h15);
    for (int i = 0; i < 4; i++) begin
      wrr(rtcas_pkg::ADDR_CTRL, {2'b10, i[1:0], 4'h0});
      repeat (2) @(posedge sys_clk_i);
      chk({6'h00, ais_hi, ais_lo}, {6'h00, i[1:0]});
    end
    bat_low <= 1'b1;
    pf_low <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    rdr(rtcas_pkg::ADDR_STAT);
    chk(v & 8'h40, 8'h40);
    chk(v & 8'h80, 8'h80);
    chk({7'h00, pfo_n}, 8'h00);
    @(posedge sys_clk_i);
    pf_low <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    chk({7'h00, pfo_n}, 8'h01);
    // oscillator still stopped here, which also arms the longer power-up
    batt <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk({7'h00, pfo_n}, 8'h00);
    batt <= 1'b0;
    n = 0;
    while (adc_upd !== 1'b1 && n < 6000) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    chk({7'h00, adc_upd}, 8'h01);
    rdr(rtcas_pkg::ADDR_ADC);
    chk(v, 8'h5a);
    rdr(rtcas_pkg::ADDR_STAT);
    chk(v & 8'h80, 8'h00);
    $display("done: registers");
  endtask
  task automatic t_alarm;
    for (int a = 7; a < 11; a++) begin
      wrr(a[6:0], 8'h80);
    end
    wrr(rtcas_pkg::ADDR_CTRL, 8'h01);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    chk({7'h00, irq}, 8'h01);
    rdr(rtcas_pkg::ADDR_STAT);
    chk(v & 8'h01, 8'h01);
    rdr(7'h08);
    repeat (3) @(posedge sys_clk_i);
    chk({7'h00, irq}, 8'h00);
    wrr(rtcas_pkg::ADDR_CTRL, 8'h00);
    repeat (150) @(posedge sys_clk_i);
    chk({7'h00, irq}, 8'h00);
    rdr(rtcas_pkg::ADDR_STAT);
    chk(v & 8'h01, 8'h01);
    $display("done: alarm");
  endtask
  task automatic t_button;
    @(posedge sys_clk_i);
    button <= 1'b1;
    wait_oe(1'b0, 10);
    chk({7'h00, oe_n}, 8'h00);
    repeat (20) @(posedge sys_clk_i);
    button <= 1'b0;
    wait_oe(1'b1, 10300);
    chk({7'h00, n >= 9800}, 8'h01);
    wait_oe(1'b0, 10);
    chk({7'h00, oe_n}, 8'h00);
    wait_oe(1'b1, 10300);
    chk({7'h00, n >= 9900}, 8'h01);
    $display("done: button");
  endtask
  task automatic t_wdog;
    wrr(rtcas_pkg::ADDR_WDOG, 8'hfd);
    rdr(rtcas_pkg::ADDR_WDOG);
    chk(v, 8'h01);
    repeat (1200) @(posedge sys_clk_i);
    strobe_en <= 1'b0;
    wait_oe(1'b0, 11000);
    chk({6'h00, n >= 9400, oe_n}, 8'h02);
    wait_oe(1'b1, 10300);
    chk({7'h00, n >= 9900}, 8'h01);
    @(posedge sys_clk_i);
    vcc_ok <= 1'b0;
    wait_oe(1'b0, 8);
    chk({6'h00, oe_n, sram_out_n}, 8'h01);
    // oscillator was stopped on battery earlier, so this power-up runs longer
    @(posedge sys_clk_i);
    vcc_ok <= 1'b1;
    wait_oe(1'b1, 12000);
    chk({7'h00, n >= 10100}, 8'h01);
    $display("done: watchdog and supply");
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #9_000_000;
    failures++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_powerup();
    t_regs();
    t_alarm();
    t_button();
    t_wdog();
    final_report();
  end
endmodule
`default_nettype wire
